// *** hdl/cplx_rd_cal.v ***
// complex pattern read calibration sequencer with register port
// assumes memory returns read data with rd_valid_i; taps applied outside
//
// Decided for this implementation: the address map and the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
`include "cplx_cal_defs.vh"

module cplx_rd_cal (
  // clock and reset
  input  wire        clock_i,
  input  wire        rst_i,
  // register port
  input  wire [7:0]  reg_addr_i,
  input  wire [31:0] reg_wdata_i,
  input  wire        reg_wr_i,
  input  wire        reg_rd_i,
  output reg  [31:0] reg_rdata_o,
  // memory command and write data
  output reg         cmd_valid_o,
  output reg         cs_n_o,
  output reg         ras_n_o,
  output reg         cas_n_o,
  output reg         we_n_o,
  output reg         act_n_o,
  output reg  [9:0]  mem_col_o,
  output reg  [63:0] wr_data_o,
  output reg  [7:0]  dm_o,
  // returned read data
  input  wire [63:0] rd_data_i,
  input  wire        rd_valid_i,
  // delay tap control
  output reg  [5:0]  tap_o,
  output reg         tap_load_o,
  output reg         tap_wr_sel_o,
  // debug and observation
  output reg  [15:0] cplx_config_o,
  output reg  [1:0]  cplx_status_o,
  output reg  [63:0] err_log_o,
  output reg  [63:0] dbg_rd_data_o,
  output reg  [63:0] dbg_exp_data_o,
  output reg         dbg_rd_valid_o,
  output reg  [2:0]  cmp_byte_o,
  output reg  [31:0] cal_progress_o,
  output reg         error_o,
  output reg         irq_o
);

  localparam [2:0] S_IDLE  = 3'h0;
  localparam [2:0] S_WRITE = 3'h1;
  localparam [2:0] S_READ  = 3'h2;
  localparam [2:0] S_WAIT  = 3'h3;
  localparam [2:0] S_EVAL  = 3'h4;
  localparam [2:0] S_DONE  = 3'h5;
  localparam [2:0] S_PROBE = 3'h6;

  // counts are worked out in integers, then cut to the counter width
  localparam integer TIMEOUT_INT = `CC_RD_TIMEOUT_CYC;
  localparam integer PROBE_INT   = `CC_PROBE_GAP_CYC;
  localparam [7:0]   TIMEOUT_CYC = TIMEOUT_INT[7:0];
  localparam [7:0]   PROBE_CYC   = PROBE_INT[7:0];

  reg  [2:0]  state_q;
  reg  [6:0]  loop_q;
  reg  [6:0]  loops_q;
  reg  [7:0]  wait_q;
  reg         found_q;
  reg  [5:0]  first_q;
  reg  [5:0]  last_q;
  reg  [2:0]  irq_stat_q;
  reg  [2:0]  irq_mask_q;
  reg  [2:0]  ev_d;
  wire [63:0] mismatch;
  wire        gross;
  wire [63:0] expect_w;
  wire        start_w;
  wire        pass_w;
  wire        found_w;

  ////////////////////////////////////////////////////////////////////////////
  // data pattern: alternating bytes that move with the loop index
  function [63:0] pattern;
    input [6:0] idx;
    begin
      pattern = {4{8'hA5 ^ {1'b0, idx}, 8'h5A ^ {idx, 1'b0}}};
    end
  endfunction

  // lanes of one byte in a 64-bit word
  function [7:0] lane;
    input [63:0] word;
    input [2:0]  sel;
    begin
      lane = word[{sel, 3'h0} +: 8];
    end
  endfunction

  assign expect_w = pattern(loop_q);
  assign start_w  = reg_wr_i && (reg_addr_i == `CC_REG_CONFIG) &&
                    reg_wdata_i[`CC_CFG_START] &&
                    ((state_q == S_IDLE) || (state_q == S_DONE));
  // a pass needs a clean lane and data that really came back
  assign pass_w   = (lane(err_log_o, cmp_byte_o) == 8'h00) && (wait_q != TIMEOUT_CYC);
  assign found_w  = found_q || pass_w;

  cplx_bit_compare u_cmp (
    .rd_word_i  (rd_data_i),
    .exp_word_i (expect_w),
    .mismatch_o (mismatch),
    .gross_o    (gross)
  );

  ////////////////////////////////////////////////////////////////////////////
  // main sequencer
  always @(posedge clock_i) begin
    if (rst_i) begin
      state_q        <= S_IDLE;
      loop_q         <= 7'h00;
      loops_q        <= 7'h00;
      wait_q         <= 8'h00;
      found_q        <= 1'b0;
      first_q        <= 6'h00;
      last_q         <= 6'h00;
      cmd_valid_o    <= 1'b0;
      cs_n_o         <= 1'b1;
      ras_n_o        <= 1'b1;
      cas_n_o        <= 1'b1;
      we_n_o         <= 1'b1;
      act_n_o        <= 1'b1;
      mem_col_o      <= 10'h000;
      wr_data_o      <= 64'h0000000000000000;
      dm_o           <= 8'h00;
      tap_o          <= 6'h00;
      tap_load_o     <= 1'b0;
      tap_wr_sel_o   <= 1'b0;
      cplx_config_o  <= `CC_CFG_RESET;
      cplx_status_o  <= `CC_ST_IDLE;
      err_log_o      <= 64'h0000000000000000;
      dbg_rd_data_o  <= 64'h0000000000000000;
      dbg_exp_data_o <= 64'h0000000000000000;
      dbg_rd_valid_o <= 1'b0;
      cmp_byte_o     <= 3'h0;
      cal_progress_o <= 32'h00000000;
      error_o        <= 1'b0;
    end else begin
      // command bus defaults to no-operation between commands
      cmd_valid_o    <= 1'b0;
      cs_n_o         <= 1'b1;
      ras_n_o        <= 1'b1;
      cas_n_o        <= 1'b1;
      we_n_o         <= 1'b1;
      act_n_o        <= 1'b1;
      tap_load_o     <= 1'b0;
      dbg_rd_valid_o <= 1'b0;
      dm_o           <= 8'h00;
      if (reg_wr_i && (reg_addr_i == `CC_REG_CONFIG)) begin
        cplx_config_o <= reg_wdata_i[15:0];
      end
      case (state_q)
        S_IDLE, S_DONE: begin
          if (start_w) begin
            loops_q        <= reg_wdata_i[`CC_CFG_LOOP_HI:`CC_CFG_LOOP_LO];
            tap_wr_sel_o   <= reg_wdata_i[`CC_CFG_WRMODE];
            cal_progress_o <= 32'h00000000 | (32'h1 << `CC_PROG_BIT);
            cplx_status_o  <= `CC_ST_BUSY;
            cmp_byte_o     <= 3'h0;
            err_log_o      <= 64'h0000000000000000;
            loop_q         <= 7'h00;
            tap_o          <= 6'h00;
            tap_load_o     <= 1'b1;
            found_q        <= 1'b0;
            error_o        <= 1'b0;
            state_q        <= S_WRITE;
          end
        end
        S_WRITE: begin
          cmd_valid_o <= 1'b1;
          cs_n_o      <= 1'b0;
          ras_n_o     <= 1'b0;
          cas_n_o     <= 1'b1;
          we_n_o      <= 1'b1;
          act_n_o     <= 1'b1;
          mem_col_o   <= {loop_q, 3'h0};
          wr_data_o   <= expect_w;
          state_q     <= S_READ;
        end
        S_READ: begin
          cmd_valid_o <= 1'b1;
          cs_n_o      <= 1'b0;
          ras_n_o     <= 1'b0;
          cas_n_o     <= 1'b1;
          we_n_o      <= 1'b0;
          act_n_o     <= 1'b1;
          wait_q      <= 8'h00;
          state_q     <= S_WAIT;
        end
        S_WAIT: begin
          if (rd_valid_i) begin
            dbg_rd_valid_o <= 1'b1;
            dbg_rd_data_o  <= rd_data_i;
            dbg_exp_data_o <= expect_w;
            err_log_o      <= err_log_o | mismatch;
            if ((loop_q >= loops_q) || gross) begin
              state_q <= S_EVAL;
            end else begin
              loop_q  <= loop_q + 7'h01;
              state_q <= S_WRITE;
            end
          end else if (wait_q == TIMEOUT_CYC) begin
            // read data never came back: treat as a stage failure
            state_q    <= S_EVAL;
            found_q    <= 1'b0;
            tap_o      <= `CC_TAP_MAX;
            tap_load_o <= 1'b1;
            err_log_o  <= 64'h0000000000000000;
          end else begin
            wait_q <= wait_q + 8'h01;
          end
        end
        S_EVAL: begin
          loop_q <= 7'h00;
          // record passing taps of the selected byte only
          if (pass_w) begin
            found_q <= 1'b1;
            last_q  <= tap_o;
            if (!found_q) begin
              first_q <= tap_o;
            end
          end
          err_log_o <= 64'h0000000000000000;
          if (tap_o != `CC_TAP_MAX) begin
            tap_o      <= tap_o + 6'h01;
            tap_load_o <= 1'b1;
            state_q    <= S_WRITE;
          end else if (!found_w) begin
            error_o       <= 1'b1;
            cplx_status_o <= `CC_ST_FAIL;
            wait_q        <= 8'h00;
            state_q       <= S_PROBE;
          end else if (cmp_byte_o != 3'h7) begin
            cmp_byte_o <= cmp_byte_o + 3'h1;
            found_q    <= 1'b0;
            tap_o      <= 6'h00;
            tap_load_o <= 1'b1;
            state_q    <= S_WRITE;
          end else begin
            cplx_status_o  <= `CC_ST_PASS;
            cal_progress_o <= 32'h00000000;
            state_q        <= S_DONE;
          end
        end
        S_PROBE: begin
          // read loop for probing; only reset leaves it
          if (wait_q >= PROBE_CYC) begin
            cmd_valid_o <= 1'b1;
            cs_n_o      <= 1'b0;
            ras_n_o     <= 1'b0;
            cas_n_o     <= 1'b1;
            we_n_o      <= 1'b0;
            act_n_o     <= 1'b1;
            wait_q      <= 8'h00;
          end else begin
            wait_q <= wait_q + 8'h01;
          end
        end
        default: begin
          state_q <= S_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt events: pass, fail, any mismatch seen on a returned word
  always @* begin
    ev_d = 3'h0;
    ev_d[`CC_IRQ_DONE]     = (state_q == S_EVAL) && (tap_o == `CC_TAP_MAX) &&
                             found_w && (cmp_byte_o == 3'h7);
    ev_d[`CC_IRQ_FAIL]     = (state_q == S_EVAL) && (tap_o == `CC_TAP_MAX) &&
                             !found_w;
    ev_d[`CC_IRQ_MISMATCH] = (state_q == S_WAIT) && rd_valid_i &&
                             (mismatch != 64'h0000000000000000);
  end

  // sticky status, write one to clear, a new event beats the clear; a set mask bit hides it
  always @(posedge clock_i) begin
    if (rst_i) begin
      irq_stat_q <= 3'h0;
      irq_mask_q <= 3'h0;
      irq_o      <= 1'b0;
    end else begin
      if (reg_wr_i && (reg_addr_i == `CC_REG_IRQ_STAT)) begin
        irq_stat_q <= (irq_stat_q & ~reg_wdata_i[2:0]) | ev_d;
      end else begin
        irq_stat_q <= irq_stat_q | ev_d;
      end
      if (reg_wr_i && (reg_addr_i == `CC_REG_IRQ_MASK)) begin
        irq_mask_q <= reg_wdata_i[2:0];
      end
      irq_o <= |(irq_stat_q & ~irq_mask_q);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read port: data one cycle after the strobe, zero for unmapped offsets
  always @(posedge clock_i) begin
    if (rst_i) begin
      reg_rdata_o <= 32'h00000000;
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        `CC_REG_CONFIG:    reg_rdata_o <= {16'h0000, cplx_config_o};
        `CC_REG_STATUS:    reg_rdata_o <= {6'h00, 2'h0, last_q, 2'h0, first_q,
                                           state_q, error_o, 1'b0, cmp_byte_o,
                                           cplx_status_o};
        `CC_REG_IRQ_STAT:  reg_rdata_o <= {29'h00000000, irq_stat_q};
        `CC_REG_IRQ_MASK:  reg_rdata_o <= {29'h00000000, irq_mask_q};
        `CC_REG_ERRLOG_LO: reg_rdata_o <= err_log_o[31:0];
        `CC_REG_ERRLOG_HI: reg_rdata_o <= err_log_o[63:32];
        `CC_REG_RDDATA_LO: reg_rdata_o <= dbg_rd_data_o[31:0];
        `CC_REG_EXPECT_LO: reg_rdata_o <= dbg_exp_data_o[31:0];
        default:           reg_rdata_o <= 32'h00000000;
      endcase
    end else begin
      reg_rdata_o <= 32'h00000000;
    end
  end

endmodule

`default_nettype wire

// *** hdl/cplx_cal_defs.vh ***
// constants for the complex pattern read calibration sequencer
// assumes word-wide register port with byte offsets, 10 MHz clock
`ifndef CPLX_CAL_DEFS_VH
`define CPLX_CAL_DEFS_VH

// register byte offsets
`define CC_REG_CONFIG    8'h00
`define CC_REG_STATUS    8'h04
`define CC_REG_IRQ_STAT  8'h08
`define CC_REG_IRQ_MASK  8'h0C
`define CC_REG_ERRLOG_LO 8'h10
`define CC_REG_ERRLOG_HI 8'h14
`define CC_REG_RDDATA_LO 8'h18
`define CC_REG_EXPECT_LO 8'h1C

// configuration word fields
`define CC_CFG_START     0
`define CC_CFG_WRMODE    1
`define CC_CFG_LOOP_HI   15
`define CC_CFG_LOOP_LO   9
`define CC_CFG_RESET     16'h0000

// progress vector bit raised while this stage runs
`define CC_PROG_BIT      28

// status codes of the two-bit stage status
`define CC_ST_IDLE       2'h0
`define CC_ST_BUSY       2'h1
`define CC_ST_PASS       2'h2
`define CC_ST_FAIL       2'h3

// interrupt status bits
`define CC_IRQ_DONE      0
`define CC_IRQ_FAIL      1
`define CC_IRQ_MISMATCH  2

// geometry
`define CC_BYTES         8
`define CC_TAP_MAX       6'h3F

// timing
`define CC_CLK_PERIOD_NS 100
`define CC_RD_TIMEOUT_NS 3200
`define CC_RD_TIMEOUT_CYC (`CC_RD_TIMEOUT_NS / `CC_CLK_PERIOD_NS)
`define CC_PROBE_GAP_NS  400
`define CC_PROBE_GAP_CYC (`CC_PROBE_GAP_NS / `CC_CLK_PERIOD_NS)

`endif

// *** hdl/cplx_bit_compare.v ***
// per-bit compare of one returned data word against the expected word
// assumes both words are stable in the cycle the caller samples the result
`timescale 1ns/10ps
`default_nettype none

module cplx_bit_compare (
  // words under compare
  input  wire [63:0] rd_word_i,
  input  wire [63:0] exp_word_i,
  // result
  output reg  [63:0] mismatch_o,
  output reg         gross_o
);

  ////////////////////////////////////////////////////////////////////////////
  // a whole byte shift is a write/read fault, not a window edge, so it
  // floods the log instead of marking only the bits that happen to differ
  // shift floods log
  always @* begin
    gross_o    = (rd_word_i != exp_word_i) &&
                 ((rd_word_i == {exp_word_i[55:0], 8'h00}) ||
                  (rd_word_i == {8'h00, exp_word_i[63:8]}));
    mismatch_o = gross_o ? 64'hFFFFFFFFFFFFFFFF : (rd_word_i ^ exp_word_i);
  end

endmodule

`default_nettype wire

// *** verif/cplx_rd_cal_properties.sv ***
// checker: port timing relations of the read calibration sequencer
// assumes it is bound onto cplx_rd_cal, which has a single clock
`timescale 1ns/10ps
`default_nettype none
module cplx_rd_cal_props (
  // clock and reset
  input wire logic        clock_i,
  input wire logic        rst_i,
  // memory side
  input wire logic        cmd_valid_o,
  input wire logic        cs_n_o,
  input wire logic        ras_n_o,
  input wire logic        cas_n_o,
  input wire logic        we_n_o,
  input wire logic        act_n_o,
  input wire logic [9:0]  mem_col_o,
  input wire logic [7:0]  dm_o,
  input wire logic [63:0] rd_data_i,
  input wire logic        rd_valid_i,
  input wire logic [5:0]  tap_o,
  input wire logic        tap_load_o,
  // observation
  input wire logic [1:0]  cplx_status_o,
  input wire logic [63:0] err_log_o,
  input wire logic [63:0] dbg_rd_data_o,
  input wire logic        dbg_rd_valid_o,
  input wire logic [2:0]  cmp_byte_o,
  input wire logic [31:0] cal_progress_o,
  input wire logic        error_o
);
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (rst_i);
  // one memory command of either kind
  sequence rd_cmd;
    cmd_valid_o && !we_n_o;
  endsequence
  sequence wr_cmd;
    cmd_valid_o && we_n_o;
  endsequence
  cmd_shape_a: assert property (cmd_valid_o |-> !cs_n_o && !ras_n_o && cas_n_o && act_n_o)
    else $error("command pins wrong");
  idle_pins_a: assert property (!cmd_valid_o |-> &{cs_n_o, ras_n_o, cas_n_o, we_n_o, act_n_o})
    else $error("idle pins not high");
  mask_off_a: assert property (dm_o == 8'h00)
    else $error("data mask asserted");
  read_back_a: assert property (wr_cmd |=> rd_cmd ##0 $stable(mem_col_o))
    else $error("no read of written column");
  dbg_align_a: assert property (dbg_rd_valid_o |-> $past(rd_valid_i) &&
    dbg_rd_data_o == $past(rd_data_i))
    else $error("debug data misaligned");
  // bit 28 rises at start and stays up through the failure read loop
  prog_bit_a: assert property (cal_progress_o == (cplx_status_o[0] ? 32'h10000000 : 32'h0))
    else $error("progress bit wrong");
  err_flag_a: assert property (error_o == (cplx_status_o == 2'h3))
    else $error("error flag and status disagree");
  // the probe loop repeats reads at a fixed five cycle period
  fail_loop_a: assert property (rd_cmd ##0 (cplx_status_o == 2'h3) |=>
    (!cmd_valid_o) [*4] ##1 rd_cmd)
    else $error("probe read loop broken");
  tap_pulse_a: assert property ($changed(tap_o) |-> tap_load_o)
    else $error("tap moved without load");
  log_clear_a: assert property (tap_load_o |-> err_log_o == 64'h0)
    else $error("log not cleared on new tap");
  byte_step_a: assert property ($past(cplx_status_o) == 2'h1 && $changed(cmp_byte_o)
    |-> cmp_byte_o == $past(cmp_byte_o) + 3'h1)
    else $error("byte groups out of order");
endmodule
bind cplx_rd_cal cplx_rd_cal_props u_props (
  .clock_i(clock_i), .rst_i(rst_i), .cmd_valid_o(cmd_valid_o), .cs_n_o(cs_n_o),
  .ras_n_o(ras_n_o), .cas_n_o(cas_n_o), .we_n_o(we_n_o), .act_n_o(act_n_o),
  .mem_col_o(mem_col_o), .dm_o(dm_o), .rd_data_i(rd_data_i), .rd_valid_i(rd_valid_i),
  .tap_o(tap_o), .tap_load_o(tap_load_o), .cplx_status_o(cplx_status_o),
  .err_log_o(err_log_o), .dbg_rd_data_o(dbg_rd_data_o), .dbg_rd_valid_o(dbg_rd_valid_o),
  .cmp_byte_o(cmp_byte_o), .cal_progress_o(cal_progress_o), .error_o(error_o));
`default_nettype wire

// *** verif/mem_model.sv ***
// behavioural memory: stores writes, returns reads three cycles later
// assumes commands one cycle wide; mode 1 never answers, 2 flips an edge bit, 3 shifts a byte
`timescale 1ns/10ps
`default_nettype none
module mem_model (
  // clock and reset
  input  wire logic        clock_i,
  input  wire logic        rst_i,
  // commands from the sequencer
  input  wire logic        cmd_valid_i,
  input  wire logic        we_n_i,
  input  wire logic [9:0]  mem_col_i,
  input  wire logic [63:0] wr_data_i,
  input  wire logic [5:0]  tap_i,
  input  wire logic [2:0]  byte_i,
  input  wire logic [1:0]  mode_i,
  // returned data
  output logic      [63:0] rd_data_o,
  output logic             rd_valid_o
);
  logic [63:0] mem_q [0:1023];
  logic [63:0] pipe_q [0:2];
  logic [63:0] hold_q;
  logic [63:0] flip;
  logic [2:0]  vld_q;
  // low taps sit outside the window: one bit of the byte under test fails
  assign flip = (mode_i == 2'h2 && tap_i < 6'h04) ? (64'h1 << {byte_i, 3'h0}) : 64'h0;
  // decode write/read and return the stored word
  always @(posedge clock_i) begin
    if (cmd_valid_i && we_n_i) mem_q[mem_col_i] <= wr_data_i;
    vld_q <= rst_i ? 3'h0 : {vld_q[1:0], cmd_valid_i && !we_n_i && mode_i != 2'h1};
    // mode 3 hands back the word one byte off, as a broken write/read path would
    pipe_q[0] <= (mode_i == 2'h3) ? {mem_q[mem_col_i][55:0], 8'h00} : mem_q[mem_col_i] ^ flip;
    pipe_q[1] <= pipe_q[0];
    pipe_q[2] <= pipe_q[1];
    hold_q <= rd_valid_o ? pipe_q[2] : hold_q;
  end
  // a released bus shows the inverse of the last word, never a copy of it
  assign rd_valid_o = vld_q[2];
  assign rd_data_o = vld_q[2] ? pipe_q[2] : ~hold_q;
endmodule
`default_nettype wire

// *** verif/tb_complex_pattern_read_calibration.sv ***
// testbench: reset, register port, full sweeps, edge bits, failure loop
// assumes mem_model on the memory side and one 10 MHz clock
`timescale 1ns/10ps
`default_nettype none
`include "cplx_cal_defs.vh"
module tb_complex_pattern_read_calibration;
  logic        clock_i, rst_i, reg_wr_i, reg_rd_i, rd_valid_i, cmd_valid_o;
  logic        cs_n_o, ras_n_o, cas_n_o, we_n_o, act_n_o, tap_load_o, tap_wr_sel_o;
  logic        dbg_rd_valid_o, error_o, irq_o;
  logic [7:0]  reg_addr_i, dm_o;
  logic [31:0] reg_wdata_i, reg_rdata_o, cal_progress_o, rd_word;
  logic [63:0] rd_data_i, wr_data_o, err_log_o, dbg_rd_data_o, dbg_exp_data_o;
  logic [9:0]  mem_col_o;
  logic [5:0]  tap_o;
  logic [15:0] cplx_config_o;
  logic [1:0]  cplx_status_o, mode;
  logic [2:0]  cmp_byte_o;
  int          errors, total_checks, wr_cnt, rd_cnt, hits;
  cplx_rd_cal u_dut (.clock_i(clock_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .cmd_valid_o(cmd_valid_o), .cs_n_o(cs_n_o),
    .ras_n_o(ras_n_o), .cas_n_o(cas_n_o), .we_n_o(we_n_o), .act_n_o(act_n_o),
    .mem_col_o(mem_col_o), .wr_data_o(wr_data_o), .dm_o(dm_o), .rd_data_i(rd_data_i),
    .rd_valid_i(rd_valid_i), .tap_o(tap_o), .tap_load_o(tap_load_o),
    .tap_wr_sel_o(tap_wr_sel_o), .cplx_config_o(cplx_config_o),
    .cplx_status_o(cplx_status_o), .err_log_o(err_log_o), .dbg_rd_data_o(dbg_rd_data_o),
    .dbg_exp_data_o(dbg_exp_data_o), .dbg_rd_valid_o(dbg_rd_valid_o),
    .cmp_byte_o(cmp_byte_o), .cal_progress_o(cal_progress_o), .error_o(error_o),
    .irq_o(irq_o));
  mem_model u_mem (.clock_i(clock_i), .rst_i(rst_i), .cmd_valid_i(cmd_valid_o),
    .we_n_i(we_n_o), .mem_col_i(mem_col_o), .wr_data_i(wr_data_o), .tap_i(tap_o),
    .byte_i(cmp_byte_o), .mode_i(mode), .rd_data_o(rd_data_i), .rd_valid_o(rd_valid_i));
  //////////////////////////////////////////////////////////////////////////////
  // 100 ns clock
  initial begin
    clock_i = 1'b0;
    forever #50 clock_i = ~clock_i;
  end
  task automatic check(input logic ok, input string msg);
    total_checks++;
    if (ok !== 1'b1) begin
      errors++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask
  // command counters and the single-bit watch during edge sweeps
  always @(posedge clock_i) begin
    if (cmd_valid_o === 1'b1 && we_n_o === 1'b1) wr_cnt++;
    if (cmd_valid_o === 1'b1 && we_n_o === 1'b0) rd_cnt++;
    if (mode == 2'h2 && dbg_rd_valid_o === 1'b1 && err_log_o !== 64'h0) begin
      hits++;
      check(err_log_o === (64'h1 << {cmp_byte_o, 3'h0}), "log not one bit");
    end
    if (mode == 2'h3 && dbg_rd_valid_o === 1'b1) begin
      hits++;
      check(err_log_o === {64{1'b1}}, "log not flooded");
    end
  end
  task automatic settle;
    @(posedge clock_i);
    #1;
  endtask
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge clock_i);
    reg_wr_i <= 1'b0;
    #1;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic reg_rd(input logic [7:0] a);
    @(posedge clock_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clock_i);
    reg_rd_i <= 1'b0;
    #1;
    rd_word = reg_rdata_o;
  endtask
  task automatic wait_status(input logic [1:0] s, input int n);
    int i;
    for (i = 0; i < n && cplx_status_o !== s; i++) settle();
    check(cplx_status_o === s, "status not reached");
  endtask
  //////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    check(cs_n_o === 1'b1 && cplx_status_o === `CC_ST_IDLE && irq_o === 1'b0, "reset");
    check(dm_o === 8'h00 && cal_progress_o === 32'h0, "reset mask");
    reg_rd(8'hFC);
    check(rd_word === 32'h0, "unmapped read");
    reg_rd(`CC_REG_CONFIG);
    check(rd_word === 32'h0, "config reset");
  endtask
  // two loops per tap, interrupt masked then opened and cleared
  task automatic t_pass;
    mode = 2'h0;
    reg_wr(`CC_REG_IRQ_MASK, 32'h7);
    wr_cnt = 0;
    rd_cnt = 0;
    reg_wr(`CC_REG_CONFIG, 32'h0201);
    check(cplx_config_o === 16'h0201, "config echo");
    wait_status(`CC_ST_BUSY, 4);
    check(cal_progress_o[`CC_PROG_BIT] === 1'b1, "progress bit");
    wait_status(`CC_ST_PASS, 12000);
    check(wr_cnt == `CC_BYTES * 128 && rd_cnt == wr_cnt, "loop count");
    check(cmp_byte_o === 3'h7 && tap_wr_sel_o === 1'b0, "last byte or mode");
    check(dbg_rd_data_o === dbg_exp_data_o && wr_data_o === dbg_exp_data_o, "data echo");
    reg_rd(`CC_REG_RDDATA_LO);
    check(rd_word === dbg_rd_data_o[31:0] && rd_word !== 32'h0, "read data reg");
    reg_rd(`CC_REG_EXPECT_LO);
    check(rd_word === dbg_exp_data_o[31:0], "expected data reg");
    settle();
    check(irq_o === 1'b0, "masked irq");
    reg_rd(`CC_REG_IRQ_STAT);
    check(rd_word[`CC_IRQ_DONE] === 1'b1, "done not sticky");
    reg_wr(`CC_REG_IRQ_MASK, 32'h0);
    settle();
    check(irq_o === 1'b1, "unmasked irq");
    reg_wr(`CC_REG_IRQ_STAT, 32'h7);
    settle();
    check(irq_o === 1'b0, "irq not cleared");
  endtask
  task automatic t_edge;
    mode = 2'h2;
    hits = 0;
    reg_wr(`CC_REG_CONFIG, 32'h0003);
    wait_status(`CC_ST_BUSY, 4);
    check(tap_wr_sel_o === 1'b1, "write centering mode");
    wait_status(`CC_ST_PASS, 8000);
    check(hits > 0, "no edge seen");
    reg_rd(`CC_REG_IRQ_STAT);
    check(rd_word[`CC_IRQ_MISMATCH] === 1'b1, "mismatch event");
  endtask
  // silent memory: timeout, failure, endless probe reads
  task automatic t_fail;
    mode = 2'h1;
    reg_wr(`CC_REG_CONFIG, 32'h0001);
    wait_status(`CC_ST_FAIL, 3000);
    check(error_o === 1'b1, "error flag");
    wr_cnt = 0;
    rd_cnt = 0;
    repeat (30) settle();
    check(wr_cnt == 0 && rd_cnt >= 5, "probe reads");
    reg_rd(`CC_REG_STATUS);
    check(rd_word[1:0] === `CC_ST_FAIL && rd_word[6] === 1'b1, "status word");
    reg_rd(`CC_REG_IRQ_STAT);
    check(rd_word[`CC_IRQ_FAIL] === 1'b1, "fail event");
  endtask
  // byte-shifted returns: every pass floods the log and the stage fails
  task automatic t_shift;
    mode = 2'h3;
    hits = 0;
    reg_wr(`CC_REG_CONFIG, 32'h0001);
    wait_status(`CC_ST_FAIL, 1000);
    check(hits > 0, "no byte shift seen");
  endtask
  task automatic finish_test;
    if (errors == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    #4000000;
    errors++;
    finish_test();
  end
  initial begin
    errors = 0;
    total_checks = 0;
    wr_cnt = 0;
    rd_cnt = 0;
    hits = 0;
    mode = 2'h0;
    rst_i = 1'b1;
    reg_wr_i = 1'b0;
    reg_rd_i = 1'b0;
    reg_addr_i = 8'h00;
    reg_wdata_i = 32'h0;
    repeat (3) @(posedge clock_i);
    rst_i <= 1'b0;
    #1;
    t_reset();
    t_pass();
    t_edge();
    t_fail();
    // reset in mid-run: only reset leaves the probe loop
    @(posedge clock_i);
    rst_i <= 1'b1;
    repeat (3) @(posedge clock_i);
    rst_i <= 1'b0;
    #1;
    t_reset();
    t_shift();
    finish_test();
  end
endmodule
`default_nettype wire
